// ### common/hpf_pkg.sv
package hpf_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned POR_DELAY_US = 500;
  localparam int unsigned POR_CYCLES = POR_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W = 24;
  localparam logic [TIMER_W-1:0] OVERCURRENT_DELAY_DEF = 24'h0186a0;
  localparam int unsigned NSLOT = 2;
  localparam logic [7:0] ADDR_CTRL_A = 8'h08;
  localparam logic [7:0] ADDR_CTRL_B = 8'h0c;
  localparam logic [7:0] ADDR_STAT_A = 8'h10;
  localparam logic [7:0] ADDR_STAT_B = 8'h14;
  localparam logic [7:0] ADDR_COMMON = 8'h18;
  localparam logic [7:0] ADDR_TIMER = 8'h1c;
  localparam int unsigned CTL_AUX_EN = 0;
  localparam int unsigned CTL_MAIN_EN = 1;
  localparam int unsigned CTL_MAIN_PG = 6;
  localparam int unsigned CTL_AUX_PG = 7;
  localparam int unsigned ST_UV = 0;
  localparam int unsigned ST_FAST = 1;
  localparam int unsigned ST_SLOW = 2;
  localparam int unsigned ST_AUXOC = 3;
  localparam int unsigned ST_SLOTOT = 4;
  localparam int unsigned ST_FAULT = 7;
  localparam int unsigned CS_OT = 1;
  localparam int unsigned CS_STBY = 2;
  localparam int unsigned CS_MASK = 3;
  localparam int unsigned CS_GPI_A = 4;
  localparam int unsigned CS_GPI_B = 5;
  localparam logic [4:0] ST_FAULT_BITS = 5'h1f;
  localparam logic [7:0] CS_RESET = 8'h00;
  localparam int unsigned SYNC_W = 11;
  typedef enum logic [1:0] {hpf_por, hpf_off, hpf_on} hpf_state_type;
endpackage

// ### dv/hpf_ctrl_sva.sv
module hpf_ctrl_chk
  import hpf_pkg::*;
#(
  parameter int unsigned POR_COUNT = POR_CYCLES
)(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic [1:0] main_on_pin, // Main on pins
  input wire logic [1:0] aux_supply_enable_pin, // Aux enable pins
  input wire logic [1:0] in_uv, // Input undervoltage
  input wire logic [1:0] main_slow_oc, // Slow overcurrent
  input wire logic [1:0] main_fast_oc, // Fast overcurrent
  input wire logic [1:0] slot_hot, // Slot hot
  input wire logic die_hot, // Die hot
  input wire logic [1:0] main_gate_on, // Main outputs on
  input wire logic [1:0] aux_on, // Aux outputs on
  input wire logic [1:0] discharge_on, // Discharge on
  input wire logic [1:0] fault_n_o, // Fault drive value
  input wire logic [1:0] fault_n_oe_n, // Fault drive enable
  input wire logic irq_n_o, // Interrupt drive value
  input wire logic standby // Standby
);
  int unsigned por_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt <= 0;
    end else if (por_cnt < POR_COUNT) begin
      por_cnt <= por_cnt + 1;
    end
  end
  a_por_outputs_off: assert property (
    por_cnt < POR_COUNT |-> main_gate_on == 2'h0 && aux_on == 2'h0) else $error("output on during power-on phase");
  a_discharge_idle: assert property (
    ((~main_gate_on & ~aux_on & ~$past(main_gate_on | aux_on)) & ~discharge_on) == 2'h0)
    else $error("off slot not discharged");
  a_discharge_live: assert property (
    ((main_gate_on | aux_on) & $past(main_gate_on | aux_on) & discharge_on) == 2'h0)
    else $error("discharge while slot on");
  a_fast_trip_main: assert property (
    main_fast_oc[0] |-> ##[1:4] !main_gate_on[0]) else $error("fast trip missed");
  a_slot_hot_off: assert property (
    slot_hot[1] && main_slow_oc[1] |-> ##[1:4] !main_gate_on[1] && !aux_on[1]) else $error("slot hot not off");
  a_die_hot_off: assert property (
    die_hot |-> ##[1:4] main_gate_on == 2'h0 && aux_on == 2'h0) else $error("die hot not off");
  a_uv_standby: assert property (
    in_uv[0] && main_gate_on[0] |-> ##[1:4] standby && !main_gate_on[0]) else $error("undervoltage missed");
  a_serial_no_fault: assert property (
    (main_on_pin[0] == 1'b0 && aux_supply_enable_pin[0] == 1'b0) [*5] |-> fault_n_oe_n[0])
    else $error("fault pin in serial mode");
  a_open_drain_low: assert property (
    fault_n_o == 2'h0 && irq_n_o == 1'b0) else $error("open drain drives high");
endmodule

bind hpf_ctrl hpf_ctrl_chk #(.POR_COUNT(POR_COUNT)) u_chk (.pclk(pclk), .presetn(presetn),
  .main_on_pin(main_on_pin), .aux_supply_enable_pin(aux_supply_enable_pin), .in_uv(in_uv),
  .main_slow_oc(main_slow_oc), .main_fast_oc(main_fast_oc), .slot_hot(slot_hot), .die_hot(die_hot),
  .main_gate_on(main_gate_on), .aux_on(aux_on), .discharge_on(discharge_on), .fault_n_o(fault_n_o),
  .fault_n_oe_n(fault_n_oe_n), .irq_n_o(irq_n_o), .standby(standby));

// ### dv/hpf_hpc.sv
module hpf_hpc #(
  parameter int unsigned POR_WAIT = 30
)(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic [1:0] req_main, // Main power wanted per slot
  input wire logic [1:0] req_aux, // Aux power wanted per slot
  input wire logic [1:0] fault_n_oe_n, // Fault pins, low asserted
  output logic [1:0] main_on_pin, // Main on pins
  output logic [1:0] aux_supply_enable_pin // Aux enable pins
);
  int unsigned wait_cnt;
  logic [1:0] held_off;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 0;
    end else if (wait_cnt < POR_WAIT) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  // drop enables on fault
  // A slot stays dropped until its request is withdrawn, so a fault never retriggers itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_off <= 2'h0;
      main_on_pin <= 2'h0;
      aux_supply_enable_pin <= 2'h0;
    end else begin
      held_off <= (held_off | ~fault_n_oe_n) & (req_main | req_aux);
      main_on_pin <= (wait_cnt < POR_WAIT) ? 2'h0 : req_main & ~held_off & fault_n_oe_n;
      aux_supply_enable_pin <= (wait_cnt < POR_WAIT) ? 2'h0 : req_aux & ~held_off & fault_n_oe_n;
    end
  end
endmodule

// ### dv/tb_top.sv
module tb_top
  import hpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, die_hot = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h10a5b;
  logic pready, pslverr, irq_n_o, irq_n_oe_n, standby;
  logic [1:0] gpi = 2'h0, in_uv = 2'h0, main_slow_oc = 2'h0, main_fast_oc = 2'h0, aux_oc = 2'h0, stby_uv = 2'h0;
  logic [1:0] slot_hot = 2'h0, req_main = 2'h0, req_aux = 2'h0, main_on_pin, aux_supply_enable_pin;
  logic [1:0] main_gate_on, aux_on, discharge_on, fault_n_o, fault_n_oe_n;
  logic [64:0] q[$];
  int n_mismatch = 0, n_tests = 0;
  hpf_ctrl #(.POR_COUNT(20)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_on_pin, .aux_supply_enable_pin, .general_input_pin(gpi), .in_uv,
    .stby_uv, .main_slow_oc, .main_fast_oc, .aux_oc, .slot_hot, .die_hot, .main_pg(main_gate_on),
    .aux_pg(aux_on), .main_gate_on, .aux_on, .discharge_on, .fault_n_o, .fault_n_oe_n, .irq_n_o,
    .irq_n_oe_n, .standby);
  hpf_hpc #(.POR_WAIT(30)) u_hpc (.pclk, .presetn, .req_main, .req_aux, .fault_n_oe_n, .main_on_pin,
    .aux_supply_enable_pin);
  initial begin
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  // Every transfer notes its expected answer; masked bits are ignored
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic [31:0] m, input logic err);
    q.push_back({err, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask
  task automatic arm();
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_A, 32'h3);
    cyc(6);
  endtask
  always @(posedge pclk) begin
    logic [64:0] x;
    if (psel && penable && pready === 1'b1) begin
      x = q.pop_front();
      n_tests++;
      if ((prdata & x[63:32]) !== x[31:0] || pslverr !== x[64]) begin
        n_mismatch++;
        $display("unexpected at %0t: %h %h vs %h %h", $time, prdata, pslverr, x[31:0], x[64]);
      end
    end
  end
  initial begin
    cyc(4000);
    n_mismatch++;
    final_report();
  end
  initial begin
    logic [31:0] r;
    cyc(10);
    presetn <= 1'b1;
    wr(ADDR_CTRL_A, 32'h3);
    rd(ADDR_CTRL_A, 32'h0, 32'hff);
    rd(ADDR_STAT_B, 32'h0, 32'hff);
    rd(ADDR_TIMER, {8'h0, OVERCURRENT_DELAY_DEF}, 32'hffffffff);
    apb(1'b0, 8'h04, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 8'h20, 32'h3, 32'h0, 32'h0, 1'b1);
    cyc(25);
    chk({main_gate_on, aux_on, discharge_on}, 8'h03);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      gpi <= r[1:0];
      cyc(5);
      rd(ADDR_COMMON, {26'h0, gpi, 4'h0}, 32'hff);
    end
    wr(ADDR_TIMER, 32'h8);
    rd(ADDR_TIMER, 32'h8, 32'hffffff);
    wr(ADDR_CTRL_A, 32'h3);
    cyc(8);
    rd(ADDR_CTRL_A, 32'hc3, 32'hff);
    chk({main_gate_on[0], aux_on[0], discharge_on[0], fault_n_oe_n[0]}, 8'hd);
    main_fast_oc <= 2'h1;
    cyc(2);
    main_fast_oc <= 2'h0;
    cyc(6);
    chk({main_gate_on[0], aux_on[0], discharge_on[0], fault_n_oe_n[0], irq_n_oe_n}, 8'h0a);
    rd(ADDR_STAT_A, 32'h02, 32'hff);
    wr(ADDR_STAT_A, 32'h02);
    rd(ADDR_STAT_A, 32'h0, 32'hff);
    chk(irq_n_oe_n, 8'h1);
    arm();
    chk(main_gate_on[0], 8'h1);
    main_slow_oc <= 2'h1;
    cyc(4);
    main_slow_oc <= 2'h0;
    cyc(3);
    main_slow_oc <= 2'h1;
    cyc(4);
    main_slow_oc <= 2'h0;
    cyc(6);
    chk(main_gate_on[0], 8'h1);
    main_slow_oc <= 2'h1;
    cyc(20);
    main_slow_oc <= 2'h0;
    cyc(4);
    chk({main_gate_on[0], aux_on[0]}, 8'h1);
    rd(ADDR_STAT_A, 32'h04, 32'hff);
    wr(ADDR_STAT_A, 32'h04);
    wr(ADDR_COMMON, 32'h08);
    arm();
    main_fast_oc <= 2'h1;
    cyc(2);
    main_fast_oc <= 2'h0;
    cyc(6);
    chk(irq_n_oe_n, 8'h1);
    rd(ADDR_STAT_A, 32'h02, 32'hff);
    wr(ADDR_STAT_A, 32'h02);
    wr(ADDR_COMMON, 32'h0);
    arm();
    aux_oc <= 2'h1;
    cyc(20);
    aux_oc <= 2'h0;
    cyc(4);
    chk({main_gate_on[0], aux_on[0]}, 8'h2);
    rd(ADDR_STAT_A, 32'h08, 32'hff);
    wr(ADDR_STAT_A, 32'h08);
    // Slot B is pin driven, so the host leaves its control register alone
    req_main <= 2'h2;
    req_aux <= 2'h2;
    cyc(10);
    chk({main_gate_on[1], aux_on[1], fault_n_oe_n[1]}, 8'h7);
    slot_hot <= 2'h2;
    main_slow_oc <= 2'h2;
    cyc(5);
    chk({main_gate_on[1], aux_on[1], fault_n_oe_n[1], irq_n_oe_n, main_gate_on[0]}, 8'h01);
    cyc(8);
    chk(fault_n_oe_n[1], 8'h1);
    rd(ADDR_STAT_B, 32'h10, 32'h10);
    slot_hot <= 2'h0;
    main_slow_oc <= 2'h0;
    req_main <= 2'h0;
    req_aux <= 2'h0;
    wr(ADDR_STAT_B, 32'h1f);
    die_hot <= 1'b1;
    cyc(3);
    die_hot <= 1'b0;
    cyc(5);
    chk({main_gate_on, aux_on}, 8'h0);
    rd(ADDR_COMMON, 32'h02, 32'h02);
    wr(ADDR_COMMON, 32'h02);
    rd(ADDR_COMMON, 32'h0, 32'h02);
    wr(ADDR_STAT_A, 32'h1f);
    arm();
    in_uv <= 2'h1;
    cyc(6);
    chk({main_gate_on[0], aux_on[0], standby}, 8'h3);
    rd(ADDR_STAT_A, 32'h01, 32'h01);
    stby_uv <= 2'h1;
    cyc(6);
    chk(aux_on[0], 8'h0);
    rd(ADDR_COMMON, 32'h04, 32'h04);
    stby_uv <= 2'h0;
    wr(ADDR_COMMON, 32'h04);
    rd(ADDR_COMMON, 32'h0, 32'h04);
    in_uv <= 2'h0;
    presetn <= 1'b0;
    cyc(2);
    chk({main_gate_on, aux_on, discharge_on}, 8'h03);
    presetn <= 1'b1;
    rd(ADDR_STAT_A, 32'h0, 32'hff);
    final_report();
  end
endmodule

// ### src/hpf_ctrl.sv
// Overview of operation
// - A switched-off slot connects discharge switches to all its outputs.
// - Standby is entered when any enabled main input drops under lockout.
// - Aux output follows pin or control bit, independent of main undervoltage.
// - Main still on at undervoltage raises fault output and unmasked interrupt.
// - Slow overcurrent past fault timer turns off all main outputs, not aux.
// - Fast-trip overcurrent turns main outputs off immediately.
// - Input undervoltage trips the breaker only while main outputs enabled.
// - Aux has no fast trip; own breaker trips on timer expiry.
// - Re-enable after trip by cycling pin or writing enable bits.
// - Trip asserts fault output in pin mode, interrupt unless masked.
// - Writing one to set fault bits releases the interrupt.
// - Slot at 140C with overcurrent turns off whole slot, asserts fault.
// - Die above 160C turns off both slots and sets overtemp flag.
// - Control bit 7 shows aux power-good, bit 6 all-four main good.
// - Common status bits 4 and 5 show the general input pins.
// - In serial-only mode fault outputs and status bit 7 stay inactive.
// - Fault bits set only with an enable active and a fault condition.
// - Fault bits stay set until the host writes one to them.
// - Interrupt works only with mask bit zero; asserts on faults.
// - In pin mode fault output asserts when enable pin and fault hold.
// - Main turn-on starts on a main-on rising edge with inputs good.
// - Power-on reset clears registers except the timer, which loads its default; outputs stay off for 500 us.
//
// Chosen here: the address map and the APB register port.
module hpf_ctrl
  import hpf_pkg::*;
#(
  parameter int unsigned POR_COUNT = POR_CYCLES
)(
  input wire logic pclk, // Clock, 100 MHz
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [1:0] main_on_pin, // Main on pins per slot
  input wire logic [1:0] aux_supply_enable_pin, // Aux enable pins per slot
  input wire logic [1:0] general_input_pin, // General inputs per slot
  input wire logic [1:0] in_uv, // Any main input under lockout
  input wire logic [1:0] stby_uv, // Standby input under lockout
  input wire logic [1:0] main_slow_oc, // Slow overcurrent, main
  input wire logic [1:0] main_fast_oc, // Fast overcurrent, main
  input wire logic [1:0] aux_oc, // Aux current limiting
  input wire logic [1:0] slot_hot, // Slot at 140C
  input wire logic die_hot, // Die above 160C
  input wire logic [1:0] main_pg, // All four main outputs good
  input wire logic [1:0] aux_pg, // Aux output good
  output logic [1:0] main_gate_on, // Main outputs on
  output logic [1:0] aux_on, // Aux output on
  output logic [1:0] discharge_on, // Discharge switches on
  output logic [1:0] fault_n_o, // Fault pins drive value (0)
  output logic [1:0] fault_n_oe_n, // Fault pins drive enable, low drives
  output logic irq_n_o, // Interrupt drive value (0)
  output logic irq_n_oe_n, // Interrupt drive enable, low drives
  output logic standby // Standby mode active
);
  logic [SYNC_W-1:0] syn;
  logic [1:0] s_uv, s_suv, s_slow, s_fast, s_aux, s_hot;
  logic s_die;
  hpf_state_type state;
  logic [31:0] por_cnt;
  logic [1:0] main_enable_bit, aux_bit;
  logic [1:0] main_trip, aux_trip;
  logic [1:0] main_on_q;
  logic [4:0] stat [NSLOT];
  logic overtemp_flag, stby_flag, irq_mask_bit;
  logic [TIMER_W-1:0] overcurrent_delay;
  logic [TIMER_W-1:0] main_tmr [NSLOT];
  logic [TIMER_W-1:0] aux_tmr [NSLOT];
  logic [1:0] main_exp, aux_exp;
  logic [1:0] hw_mode, main_req, aux_req;
  logic [1:0] main_cond, aux_cond, any_cond;
  logic wr, rd;
  logic run;

  hpf_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({die_hot, slot_hot, aux_oc, main_fast_oc, main_slow_oc, in_uv}),
    .sync_out(syn)
  );
  assign s_uv = syn[1:0];
  assign s_slow = syn[3:2];
  assign s_fast = syn[5:4];
  assign s_aux = syn[7:6];
  assign s_hot = syn[9:8];
  assign s_die = syn[10];

  // Standby-supply lockout shares the main lockout bit set per slot
  logic [1:0] suv1, suv2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suv1 <= '0;
      suv2 <= '0;
    end else begin
      suv1 <= stby_uv;
      suv2 <= suv1;
    end
  end
  assign s_suv = suv2;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign run = (state != hpf_por);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a[7:2] == r[7:2];
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= hpf_por;
      por_cnt <= '0;
    end else begin
      case (state)
        hpf_por: begin
          if (por_cnt == POR_COUNT - 1) begin
            state <= hpf_off;
          end else begin
            por_cnt <= por_cnt + 32'd1;
          end
        end
        // Once out of the hold-off the block stays live until the next reset
        default: state <= hpf_off;
      endcase
    end
  end

  assign aux_req = aux_supply_enable_pin | aux_bit;
  assign main_req = main_on_pin | main_enable_bit;
  assign hw_mode = main_on_pin | aux_supply_enable_pin;

  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          main_tmr[g] <= '0;
        end else if (!s_slow[g] || !main_gate_on[g]) begin
          main_tmr[g] <= '0;
        end else if (!main_exp[g]) begin
          main_tmr[g] <= main_tmr[g] + 1'b1;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          aux_tmr[g] <= '0;
        end else if (!s_aux[g] || !aux_on[g]) begin
          aux_tmr[g] <= '0;
        end else if (!aux_exp[g]) begin
          aux_tmr[g] <= aux_tmr[g] + 1'b1;
        end
      end
      assign main_exp[g] = (main_tmr[g] >= overcurrent_delay);
      assign aux_exp[g] = (aux_tmr[g] >= overcurrent_delay);

      assign main_cond[g] = (main_gate_on[g] && (s_uv[g] || s_suv[g])) || s_fast[g]
        || (s_slow[g] && main_exp[g]) || (s_slow[g] && s_hot[g]) || s_die;
      assign aux_cond[g] = (s_aux[g] && aux_exp[g]) || (s_slow[g] && s_hot[g]) || s_die;
      assign any_cond[g] = (main_req[g] || aux_req[g]) && (main_cond[g] || aux_cond[g]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          main_trip[g] <= 1'b0;
          aux_trip[g] <= 1'b0;
        end else begin
          if (!main_req[g]) begin
            main_trip[g] <= 1'b0;
          end else if (main_cond[g]) begin
            main_trip[g] <= 1'b1;
          end
          if (!aux_req[g]) begin
            aux_trip[g] <= 1'b0;
          end else if (aux_cond[g]) begin
            aux_trip[g] <= 1'b1;
          end
        end
      end

      // main on after edge with inputs good
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          main_gate_on[g] <= 1'b0;
          aux_on[g] <= 1'b0;
          discharge_on[g] <= 1'b1;
          main_on_q[g] <= 1'b0;
        end else begin
          main_on_q[g] <= main_on_pin[g];
          // Aux overcurrent has its own breaker and leaves the main outputs alone
          if (!run || !main_req[g] || main_trip[g] || main_cond[g]) begin
            main_gate_on[g] <= 1'b0;
          end else if (((main_on_pin[g] && !main_on_q[g]) || main_enable_bit[g]) && !s_uv[g]) begin
            main_gate_on[g] <= 1'b1;
          end
          aux_on[g] <= run && aux_req[g] && !aux_trip[g] && !aux_cond[g] && !s_suv[g];
          discharge_on[g] <= !(main_gate_on[g] || aux_on[g]);
        end
      end

      logic [ST_SLOTOT:ST_UV] st_set;
      assign st_set[ST_UV] = main_gate_on[g] && (s_uv[g] || s_suv[g]);
      assign st_set[ST_FAST] = s_fast[g];
      assign st_set[ST_SLOW] = s_slow[g] && main_exp[g];
      assign st_set[ST_AUXOC] = s_aux[g] && aux_exp[g];
      assign st_set[ST_SLOTOT] = s_slow[g] && s_hot[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat[g] <= '0;
        end else begin
          stat[g] <= (stat[g] & ~(wr && hit(paddr, g ? ADDR_STAT_B : ADDR_STAT_A) ? pwdata[ST_SLOTOT:ST_UV] : '0))
            | ((run && (main_req[g] || aux_req[g])) ? st_set : '0);
        end
      end

      // fault pin only in pin mode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fault_n_oe_n[g] <= 1'b1;
          fault_n_o[g] <= 1'b0;
        end else begin
          fault_n_o[g] <= 1'b0;
          fault_n_oe_n[g] <= !(run && hw_mode[g] && (any_cond[g] || main_trip[g] || aux_trip[g]));
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby <= 1'b0;
    end else begin
      standby <= |(s_uv & main_req);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overtemp_flag <= 1'b0;
      stby_flag <= 1'b0;
      irq_mask_bit <= CS_RESET[CS_MASK];
    end else begin
      if (run && s_die && |(main_req | aux_req)) begin
        overtemp_flag <= 1'b1;
      end else if (wr && hit(paddr, ADDR_COMMON) && pwdata[CS_OT]) begin
        overtemp_flag <= 1'b0;
      end
      if (run && |(s_suv & (main_req | aux_req))) begin
        stby_flag <= 1'b1;
      end else if (wr && hit(paddr, ADDR_COMMON) && pwdata[CS_STBY]) begin
        stby_flag <= 1'b0;
      end
      if (wr && hit(paddr, ADDR_COMMON)) begin
        irq_mask_bit <= pwdata[CS_MASK];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_oe_n <= 1'b1;
      irq_n_o <= 1'b0;
    end else begin
      irq_n_o <= 1'b0;
      irq_n_oe_n <= !(!irq_mask_bit && (|stat[0] || |stat[1] || overtemp_flag || stby_flag));
    end
  end

  // Enable bits and timer setting; leaves pin/bit arbitration to the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_enable_bit <= '0;
      aux_bit <= '0;
      overcurrent_delay <= OVERCURRENT_DELAY_DEF;
    end else begin
      if (wr && run && hit(paddr, ADDR_CTRL_A)) begin
        main_enable_bit[0] <= pwdata[CTL_MAIN_EN];
        aux_bit[0] <= pwdata[CTL_AUX_EN];
      end else if (wr && run && hit(paddr, ADDR_CTRL_B)) begin
        main_enable_bit[1] <= pwdata[CTL_MAIN_EN];
        aux_bit[1] <= pwdata[CTL_AUX_EN];
      end else if (wr && hit(paddr, ADDR_TIMER)) begin
        overcurrent_delay <= pwdata[TIMER_W-1:0];
      end
    end
  end

  function automatic logic [7:0] ctl_rd(input int s);
    logic [7:0] v;
    v = '0;
    v[CTL_AUX_EN] = aux_bit[s];
    v[CTL_MAIN_EN] = main_enable_bit[s];
    v[CTL_MAIN_PG] = main_pg[s] && main_gate_on[s];
    v[CTL_AUX_PG] = aux_pg[s] && aux_on[s];
    return v;
  endfunction

  function automatic logic [7:0] st_rd(input int s);
    logic [7:0] v;
    v = {3'h0, stat[s]};
    v[ST_FAULT] = hw_mode[s] && !fault_n_oe_n[s];
    return v;
  endfunction

  // APB read, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        if (!(hit(paddr, ADDR_CTRL_A) || hit(paddr, ADDR_CTRL_B) || hit(paddr, ADDR_STAT_A)
            || hit(paddr, ADDR_STAT_B) || hit(paddr, ADDR_COMMON) || hit(paddr, ADDR_TIMER))) begin
          pslverr <= 1'b1;
        end
        if (rd) begin
          if (hit(paddr, ADDR_CTRL_A)) begin
            prdata <= {24'h000000, ctl_rd(0)};
          end else if (hit(paddr, ADDR_CTRL_B)) begin
            prdata <= {24'h000000, ctl_rd(1)};
          end else if (hit(paddr, ADDR_STAT_A)) begin
            prdata <= {24'h000000, st_rd(0)};
          end else if (hit(paddr, ADDR_STAT_B)) begin
            prdata <= {24'h000000, st_rd(1)};
          end else if (hit(paddr, ADDR_COMMON)) begin
            prdata <= {26'h0000000, general_input_pin[1], general_input_pin[0],
              irq_mask_bit, stby_flag, overtemp_flag, 1'b0};
          end else if (hit(paddr, ADDR_TIMER)) begin
            prdata <= {8'h00, overcurrent_delay};
          end
        end
      end
    end
  end
endmodule

// ### src/hpf_sync.sv
module hpf_sync
  import hpf_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic [SYNC_W-1:0] async_in, // Raw comparator levels
  output logic [SYNC_W-1:0] sync_out // Synchronised levels
);
  logic [SYNC_W-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
